/* File: design/fault_resp_pkg.sv */
// constants, types and decode functions for the per-channel fault response block
// assumes one 200 MHz clock and a command port that delivers whole byte writes
// What this block does
// - code 0xB8: shut down, retry without limit
// - code 0x4n: shut down, latch until cycled
// - code 0x78+n: shut down, retry continuously
// - 0x4n/0x78+n act after n*10us persistence
// - bad overvoltage code: discard write, flag comm fault
// - response 00: pull output down while overvoltage
// - response 01: keep running delay, then retry setting
// - response 10: disable then retry; 11 comm fault
// - retry 000 latches off; else retry each interval
// - bits 2:0 are delay in 10us steps
// - set sticky status, alert unless masked
// - undervoltage sets three status bits, alerts
// - undervoltage masked until start-up conditions met
// - undervoltage masked when inactive or ramping
// - undervoltage response 00: report, keep running
// - turn-on timeout sets three status bits, alerts
// - timeout response zero disables timeout response
// - discontinuous mode until turn-on limit exceeded
// - overcurrent sets four status bits, alerts
// - overcurrent default 00: constant-current limit; 01 unsupported
// - 10: limit for delay then retry; 11 immediate
// - overcurrent delay 16ms units; 000 needs run cycle
// - retry interval programmable, 120ms to 167.77s
// - overvoltage also accepts 0x00 and 0x80
package fault_resp_pkg;
  localparam int CLK_PERIOD_NS    = 5;
  localparam int TICK_NS          = 10000;
  localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W           = 12;
  localparam int OC_UNIT_MS       = 16;
  localparam int OC_UNIT_TICKS    = OC_UNIT_MS * 1000000 / TICK_NS;
  localparam int RETRY_MIN_MS     = 120;
  localparam int RETRY_MIN_TICKS  = RETRY_MIN_MS * 1000000 / TICK_NS;
  localparam int TW               = 24;
  localparam int NTIMER           = 4;
  localparam int T_OV             = 0;
  localparam int T_UV             = 1;
  localparam int T_OC             = 2;
  localparam int T_RETRY          = 3;

  localparam logic [7:0] CMD_OV_ACTION  = 8'h41;
  localparam logic [7:0] CMD_UV_ACTION  = 8'h45;
  localparam logic [7:0] CMD_OC_ACTION  = 8'h47;
  localparam logic [7:0] CMD_TON_ACTION = 8'h63;
  localparam logic [7:0] OV_RESET       = 8'hB8;
  localparam logic [7:0] UV_RESET       = 8'hB8;
  localparam logic [7:0] TON_RESET      = 8'hB8;
  localparam logic [7:0] OC_RESET       = 8'h00;

  localparam logic [7:0] OV_PULL_DOWN_ONLY  = 8'h00;
  localparam logic [7:0] OV_OFF_NO_RETRY    = 8'h80;
  localparam logic [7:0] OV_OFF_RETRY       = 8'hB8;
  localparam logic [7:0] OV_GLITCH_NO_RETRY = 8'h40;
  localparam logic [7:0] OV_GLITCH_RETRY    = 8'h78;
  localparam logic [7:0] OV_N_MASK          = 8'hF8;
  localparam logic [7:0] TON_DISABLED       = 8'h00;

  localparam logic [1:0] RESP_PASSIVE  = 2'b00;
  localparam logic [1:0] RESP_DELAYED  = 2'b01;
  localparam logic [1:0] RESP_SHUTDOWN = 2'b10;
  localparam logic [1:0] RESP_TOP      = 2'b11;
  localparam logic [2:0] RETRY_NONE    = 3'b000;

  // status bit positions
  localparam int SB_NONE   = 0;
  localparam int SB_COMM   = 1;
  localparam int SB_IOC    = 4;
  localparam int SB_VOV    = 5;
  localparam int SW_IOUT   = 6;
  localparam int SW_VOUT   = 7;
  localparam int SV_OV     = 7;
  localparam int SV_UV     = 4;
  localparam int SV_TON    = 2;
  localparam int SI_OC     = 7;
  // alert mask bit positions
  localparam int AM_OV     = 0;
  localparam int AM_UV     = 1;
  localparam int AM_TON    = 2;
  localparam int AM_OC     = 3;
  localparam int AM_COMM   = 4;

  typedef enum logic [1:0] {
    ST_OFF        = 2'b00,
    ST_ON         = 2'b01,
    ST_RETRY_WAIT = 2'b10,
    ST_LATCHED    = 2'b11
  } chan_state_t;

  function automatic logic [1:0] resp_of(input logic [7:0] v);
    return v[7:6];
  endfunction : resp_of

  function automatic logic [2:0] retry_of(input logic [7:0] v);
    return v[5:3];
  endfunction : retry_of

  function automatic logic [2:0] delay_of(input logic [7:0] v);
    return v[2:0];
  endfunction : delay_of

  function automatic logic ov_code_ok(input logic [7:0] v);
    return (v == OV_PULL_DOWN_ONLY) || (v == OV_OFF_NO_RETRY) || (v == OV_OFF_RETRY)
        || ((v & OV_N_MASK) == OV_GLITCH_NO_RETRY) || ((v & OV_N_MASK) == OV_GLITCH_RETRY);
  endfunction : ov_code_ok
endpackage : fault_resp_pkg

/* File: design/fault_timer_if.sv */
// carrier between the channel logic and one persistence/delay timer
// assumes the tick and clock come in on the timer's own ports
`timescale 1ns/100ps
`default_nettype none
interface fault_timer_if import fault_resp_pkg::*; ();
  logic          run;
  logic [TW-1:0] limit;
  logic          done;
  modport owner (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface : fault_timer_if
`default_nettype wire

/* File: design/fault_timer.sv */
// tick counter that reports when a condition has held for limit ticks
// assumes tick is a one-cycle pulse every 10 us and run drops to restart
`timescale 1ns/100ps
`default_nettype none
module fault_timer import fault_resp_pkg::*; (
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    ce,
  input  wire logic    tick,
  fault_timer_if.timer tif
);
  typedef struct packed {
    logic [TW-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!tif.run) begin
      s_d.cnt = '0;
    end else if (tick && !(&s_q.cnt)) begin
      s_d.cnt = s_q.cnt + TW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // a zero limit fires in the cycle the condition appears
  assign tif.done = tif.run && (s_q.cnt >= tif.limit);
endmodule : fault_timer
`default_nettype wire

/* File: design/fault_response.sv */
// per-channel output fault response: action registers, shutdown/retry sequencer, status
// assumes detector inputs are synchronous levels and commands arrive as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module fault_response import fault_resp_pkg::*; #(
  parameter int OC_UNIT_TICKS_P   = OC_UNIT_TICKS,
  parameter int RETRY_MIN_TICKS_P = RETRY_MIN_TICKS
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          cmd_write,
  input  wire logic          cmd_read,
  input  wire logic [7:0]    cmd_code,
  input  wire logic [7:0]    cmd_data,
  input  wire logic          clear_faults,
  input  wire logic          reset_cmd,
  input  wire logic          run_pin,
  input  wire logic          op_on,
  input  wire logic          ov_detect,
  input  wire logic          uv_detect,
  input  wire logic          uv_warn_detect,
  input  wire logic          uv_reached,
  input  wire logic          oc_detect,
  input  wire logic          ton_elapsed,
  input  wire logic          ton_delay_done,
  input  wire logic          ton_rise_active,
  input  wire logic          toff_fall_active,
  input  wire logic [4:0]    alert_mask,
  input  wire logic [TW-1:0] retry_ticks,
  output logic               out_enable,
  output logic               pull_down,
  output logic               current_limit,
  output logic               dcm_mode,
  output logic               uv_warn,
  output logic               alert_o,
  output logic               alert_oe_n,
  output logic [7:0]         status_byte,
  output logic [7:0]         status_word_hi,
  output logic [7:0]         status_vout,
  output logic [7:0]         status_iout,
  output logic [7:0]         rd_data,
  output logic               rd_valid
);
  typedef struct packed {
    chan_state_t       st;
    logic [7:0]        ov_act;
    logic [7:0]        uv_act;
    logic [7:0]        oc_act;
    logic [7:0]        ton_act;
    logic [7:0]        sbyte;
    logic [7:0]        sword;
    logic [7:0]        svout;
    logic [7:0]        siout;
    logic              on_prev;
    logic              run_prev;
    logic              oc_lock;
    logic              uv_seen;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic              en;
    logic              pd;
    logic              cl;
    logic              dcm;
    logic              uvw;
    logic              alert_oe_n;
    logic [7:0]        rd;
    logic              rdv;
  } main_state_t;

  main_state_t s_q;
  main_state_t s_d;

  logic              on_cmd;
  logic              uv_ok;
  logic              uv_evt;
  logic              ton_evt;
  logic [3:0]        off_req;
  logic [3:0]        may_retry;
  logic              any_off;
  logic              latch_off;
  logic              oc_latch;
  logic [NTIMER-1:0] t_run;
  logic [TW-1:0]     t_lim [NTIMER];
  logic [NTIMER-1:0] t_done;

  genvar gi;
  generate
    for (gi = 0; gi < NTIMER; gi++) begin : g_tmr
      fault_timer_if tif ();
      assign tif.run    = t_run[gi];
      assign tif.limit  = t_lim[gi];
      assign t_done[gi] = tif.done;
      fault_timer u_tmr (
        .clock (clock),
        .rst   (rst),
        .ce    (ce),
        .tick  (s_q.tick),
        .tif   (tif.timer)
      );
    end
  endgenerate

  assign on_cmd = run_pin && op_on;
  // undervoltage only counts once the start-up has settled
  assign uv_ok   = on_cmd && (s_q.st == ST_ON) && ton_delay_done && !ton_rise_active
                && !toff_fall_active && s_q.uv_seen && !oc_detect;
  assign uv_evt  = uv_detect && uv_ok;
  assign ton_evt = on_cmd && (s_q.st == ST_ON) && ton_elapsed && !s_q.uv_seen
                && (s_q.ton_act != TON_DISABLED);

  // persistence and delay timers
  always_comb begin
    t_run[T_OV]    = ov_detect && (s_q.st == ST_ON) && resp_of(s_q.ov_act) == RESP_DELAYED;
    t_lim[T_OV]    = TW'(delay_of(s_q.ov_act));
    t_run[T_UV]    = uv_evt && resp_of(s_q.uv_act) == RESP_DELAYED;
    t_lim[T_UV]    = TW'(delay_of(s_q.uv_act));
    t_run[T_OC]    = oc_detect && (s_q.st == ST_ON) && resp_of(s_q.oc_act) == RESP_SHUTDOWN;
    t_lim[T_OC]    = TW'(delay_of(s_q.oc_act)) * TW'(OC_UNIT_TICKS_P);
    t_run[T_RETRY] = (s_q.st == ST_RETRY_WAIT);
    t_lim[T_RETRY] = (retry_ticks < TW'(RETRY_MIN_TICKS_P)) ? TW'(RETRY_MIN_TICKS_P)
                   : retry_ticks;
  end

  // shutdown requests from each fault source
  always_comb begin
    off_req[0]   = ov_detect && (s_q.st == ST_ON) && ((resp_of(s_q.ov_act) == RESP_SHUTDOWN)
                || (resp_of(s_q.ov_act) == RESP_DELAYED && t_done[T_OV]));
    off_req[1]   = uv_evt && ((resp_of(s_q.uv_act) == RESP_SHUTDOWN)
                || (resp_of(s_q.uv_act) == RESP_DELAYED && t_done[T_UV]));
    off_req[2]   = ton_evt && resp_of(s_q.ton_act) == RESP_SHUTDOWN;
    off_req[3]   = oc_detect && (s_q.st == ST_ON) && ((resp_of(s_q.oc_act) == RESP_TOP)
                || (resp_of(s_q.oc_act) == RESP_SHUTDOWN && t_done[T_OC]));
    may_retry[0] = retry_of(s_q.ov_act) != RETRY_NONE;
    may_retry[1] = retry_of(s_q.uv_act) != RETRY_NONE;
    may_retry[2] = retry_of(s_q.ton_act) != RETRY_NONE;
    may_retry[3] = retry_of(s_q.oc_act) != RETRY_NONE;
    any_off      = |off_req;
    latch_off    = |(off_req & ~may_retry);
    oc_latch     = off_req[3] && !may_retry[3];
  end

  always_comb begin
    s_d          = s_q;
    s_d.on_prev  = on_cmd;
    s_d.run_prev = run_pin;
    s_d.rdv      = 1'b0;
    s_d.tick     = 1'b0;
    s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1);
    if (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end
    if (!on_cmd) begin
      s_d.uv_seen = 1'b0;
    end else if (uv_reached && s_q.st == ST_ON) begin
      s_d.uv_seen = 1'b1;
    end

    // command writes; unknown action codes are dropped and flagged
    if (cmd_write) begin
      case (cmd_code)
        CMD_OV_ACTION: begin
          if (ov_code_ok(cmd_data)) s_d.ov_act = cmd_data;
          else s_d.sbyte[SB_COMM] = 1'b1;
        end
        CMD_UV_ACTION: begin
          if (resp_of(cmd_data) != RESP_TOP) s_d.uv_act = cmd_data;
          else s_d.sbyte[SB_COMM] = 1'b1;
        end
        CMD_OC_ACTION: begin
          if (resp_of(cmd_data) != RESP_DELAYED) s_d.oc_act = cmd_data;
          else s_d.sbyte[SB_COMM] = 1'b1;
        end
        CMD_TON_ACTION: begin
          if (resp_of(cmd_data) == RESP_PASSIVE || resp_of(cmd_data) == RESP_SHUTDOWN) begin
            s_d.ton_act = cmd_data;
          end else begin
            s_d.sbyte[SB_COMM] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (cmd_read) begin
      s_d.rdv = 1'b1;
      case (cmd_code)
        CMD_OV_ACTION:  s_d.rd = s_q.ov_act;
        CMD_UV_ACTION:  s_d.rd = s_q.uv_act;
        CMD_OC_ACTION:  s_d.rd = s_q.oc_act;
        CMD_TON_ACTION: s_d.rd = s_q.ton_act;
        default:        s_d.rd = 8'h00;
      endcase
    end

    // sticky status: a clear and a new event in one cycle leave the bit set
    if (clear_faults || reset_cmd || (on_cmd && !s_q.on_prev)) begin
      s_d.sbyte = '0;
      s_d.sword = '0;
      s_d.svout = '0;
      s_d.siout = '0;
    end
    if (cmd_write && ((cmd_code == CMD_OV_ACTION && !ov_code_ok(cmd_data))
        || (cmd_code == CMD_UV_ACTION && resp_of(cmd_data) == RESP_TOP)
        || (cmd_code == CMD_OC_ACTION && resp_of(cmd_data) == RESP_DELAYED)
        || (cmd_code == CMD_TON_ACTION && (resp_of(cmd_data) == RESP_DELAYED
        || resp_of(cmd_data) == RESP_TOP)))) begin
      s_d.sbyte[SB_COMM] = 1'b1;
    end
    if (ov_detect && on_cmd) begin
      s_d.sbyte[SB_VOV]  = 1'b1;
      s_d.sword[SW_VOUT] = 1'b1;
      s_d.svout[SV_OV]   = 1'b1;
    end
    if (uv_evt) begin
      s_d.sbyte[SB_NONE] = 1'b1;
      s_d.sword[SW_VOUT] = 1'b1;
      s_d.svout[SV_UV]   = 1'b1;
    end
    if (ton_evt) begin
      s_d.sbyte[SB_NONE] = 1'b1;
      s_d.sword[SW_VOUT] = 1'b1;
      s_d.svout[SV_TON]  = 1'b1;
    end
    if (oc_detect && on_cmd) begin
      s_d.sbyte[SB_NONE] = 1'b1;
      s_d.sbyte[SB_IOC]  = 1'b1;
      s_d.sword[SW_IOUT] = 1'b1;
      s_d.siout[SI_OC]   = 1'b1;
    end
    s_d.alert_oe_n = !((s_d.svout[SV_OV] && !alert_mask[AM_OV])
                    || (s_d.svout[SV_UV] && !alert_mask[AM_UV])
                    || (s_d.svout[SV_TON] && !alert_mask[AM_TON])
                    || (s_d.siout[SI_OC] && !alert_mask[AM_OC])
                    || (s_d.sbyte[SB_COMM] && !alert_mask[AM_COMM]));

    // channel sequencer
    case (s_q.st)
      ST_OFF: begin
        if (on_cmd) s_d.st = ST_ON;
      end
      ST_ON: begin
        if (!on_cmd) s_d.st = ST_OFF;
        else if (latch_off) s_d.st = ST_LATCHED;
        else if (any_off) s_d.st = ST_RETRY_WAIT;
        s_d.oc_lock = oc_latch;
      end
      ST_RETRY_WAIT: begin
        if (!on_cmd) s_d.st = ST_OFF;
        else if (t_done[T_RETRY]) s_d.st = ST_ON;
      end
      ST_LATCHED: begin
        // an overcurrent latch yields only to a falling run pin or to reset_cmd
        if (s_q.oc_lock ? (!run_pin && s_q.run_prev) : !on_cmd) s_d.st = ST_OFF;
      end
      default: s_d.st = ST_OFF;
    endcase
    if (reset_cmd) s_d.st = ST_OFF;

    s_d.en  = on_cmd && (s_d.st == ST_ON);
    s_d.pd  = on_cmd && ov_detect && (s_q.ov_act == OV_PULL_DOWN_ONLY);
    s_d.cl  = s_d.en && oc_detect && (resp_of(s_q.oc_act) == RESP_PASSIVE
            || resp_of(s_q.oc_act) == RESP_SHUTDOWN);
    s_d.dcm = s_d.en && !ton_elapsed;
    s_d.uvw = uv_warn_detect && uv_ok;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q            <= '0;
      s_q.st         <= ST_OFF;
      s_q.ov_act     <= OV_RESET;
      s_q.uv_act     <= UV_RESET;
      s_q.oc_act     <= OC_RESET;
      s_q.ton_act    <= TON_RESET;
      s_q.alert_oe_n <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign out_enable     = s_q.en;
  assign pull_down      = s_q.pd;
  assign current_limit  = s_q.cl;
  assign dcm_mode       = s_q.dcm;
  assign uv_warn        = s_q.uvw;
  assign alert_o        = 1'b0;
  assign alert_oe_n     = s_q.alert_oe_n;
  assign status_byte    = s_q.sbyte;
  assign status_word_hi = s_q.sword;
  assign status_vout    = s_q.svout;
  assign status_iout    = s_q.siout;
  assign rd_data        = s_q.rd;
  assign rd_valid       = s_q.rdv;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_bad_ov_write: assert property (
    ce && cmd_write && cmd_code == CMD_OV_ACTION && !ov_code_ok(cmd_data)
    |=> $stable(s_q.ov_act) && status_byte[SB_COMM])
    else $error("bad overvoltage code was stored or not flagged");
  chk_ov_immediate: assert property (
    ce && s_q.st == ST_ON && on_cmd && !reset_cmd && ov_detect && s_q.ov_act == OV_OFF_RETRY
    |=> s_q.st == ST_RETRY_WAIT && !out_enable)
    else $error("overvoltage 0xB8 did not shut down to retry");
  chk_ov_latch: assert property (
    ce && s_q.st == ST_ON && on_cmd && !reset_cmd && off_req[0]
    && retry_of(s_q.ov_act) == RETRY_NONE |=> s_q.st == ST_LATCHED)
    else $error("non-retry overvoltage did not latch");
  chk_latched_hold: assert property (
    s_q.st == ST_LATCHED && on_cmd && !reset_cmd |=> s_q.st == ST_LATCHED && !out_enable)
    else $error("latched shutdown left without cycling");
  chk_pull_down: assert property (
    ce && on_cmd && ov_detect && s_q.ov_act == OV_PULL_DOWN_ONLY |=> pull_down)
    else $error("pull down missing under overvoltage");
  chk_uv_masked: assert property (
    ce && (ton_rise_active || toff_fall_active || !on_cmd) |=> !uv_warn)
    else $error("undervoltage warning during masking");
  chk_oc_limit: assert property (
    ce && s_q.st == ST_ON && on_cmd && !reset_cmd && oc_detect && s_q.oc_act == OC_RESET
    |=> current_limit && s_q.st == ST_ON)
    else $error("default overcurrent response did not limit");
  chk_oc_status: assert property (
    ce && oc_detect && on_cmd |=> status_byte[SB_NONE] && status_byte[SB_IOC]
    && status_word_hi[SW_IOUT] && status_iout[SI_OC])
    else $error("overcurrent status bits missing");
  chk_ton_zero: assert property (
    ce && s_q.ton_act == TON_DISABLED && !status_vout[SV_TON] |=> !status_vout[SV_TON])
    else $error("disabled turn-on timeout still responded");
  chk_alert_drive: assert property (
    ce && status_vout[SV_OV] && !alert_mask[AM_OV] && $stable(status_vout) && !clear_faults
    && !reset_cmd && !(on_cmd && !s_q.on_prev) |=> !alert_oe_n)
    else $error("alert not driven for unmasked fault");
  chk_uv_status: assert property (
    ce && uv_evt |=> status_byte[SB_NONE] && status_word_hi[SW_VOUT] && status_vout[SV_UV])
    else $error("undervoltage status bits missing");
  chk_ton_status: assert property (
    ce && ton_evt |=> status_byte[SB_NONE] && status_word_hi[SW_VOUT] && status_vout[SV_TON])
    else $error("turn-on timeout status bits missing");
  chk_oc_run_latch: assert property (
    s_q.st == ST_LATCHED && s_q.oc_lock && run_pin && !reset_cmd |=> s_q.st == ST_LATCHED)
    else $error("overcurrent latch left without a run pin cycle");

  cov_retry_cycle: cover property (s_q.st == ST_RETRY_WAIT ##1 s_q.st == ST_ON);
  cov_latched: cover property (s_q.st == ST_ON ##1 s_q.st == ST_LATCHED);
  cov_uv_fault: cover property (uv_evt && s_q.uv_act != UV_RESET);
  cov_comm_fault: cover property (ce && cmd_write && cmd_code == CMD_UV_ACTION
    && resp_of(cmd_data) == RESP_TOP);
endmodule : fault_response
`default_nettype wire

/* File: verification/host_model.sv */
// host and run pin stand-in issuing byte commands to the fault block
// assumes its tasks are called just after a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clock,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            cmd_write,
  output logic            cmd_read,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_data,
  output logic            clear_faults,
  output logic            run_pin,
  output logic            op_on
);
  initial begin
    {cmd_write, cmd_read, clear_faults, run_pin, op_on} = 5'h00;
    {cmd_code, cmd_data} = 16'h0000;
  end
  // a zero timeout code goes out only when the caller asks for it
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd_code  = c;
    cmd_data  = d;
    cmd_write = 1'b1;
    @(negedge clock);
    cmd_write = 1'b0;
    cmd_data  = ~d;
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    int n = 0;
    cmd_code = c;
    cmd_read = 1'b1;
    @(negedge clock);
    cmd_read = 1'b0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 8'hEE;
    @(negedge clock);
  endtask : rd
  task automatic clr();
    clear_faults = 1'b1;
    @(negedge clock);
    clear_faults = 1'b0;
  endtask : clr
  task automatic run(input logic r, input logic o);
    run_pin = r;
    op_on   = o;
  endtask : run
endmodule : host_model
`default_nettype wire

/* File: verification/test_fault_response.sv */
// self-checking bench for the per-channel fault response block
// assumes short timer parameters; tick stays 2000 cycles
`timescale 1ns/100ps
`default_nettype none
module test_fault_response import fault_resp_pkg::*;;
  logic          clock, rst, ce, ov_detect, uv_detect, uv_warn_detect, uv_reached;
  logic          oc_detect, ton_elapsed, ton_delay_done, ton_rise_active, toff_fall_active;
  logic          cmd_write, cmd_read, clear_faults, reset_cmd, run_pin, op_on, rd_valid;
  logic          out_enable, pull_down, current_limit, dcm_mode, uv_warn, alert_o, alert_oe_n;
  logic [4:0]    alert_mask;
  logic [TW-1:0] retry_ticks;
  logic [7:0]    cmd_code, cmd_data, rd_data, rv, status_byte, status_word_hi;
  logic [7:0]    status_vout, status_iout;
  int            fail_count, tests_run;

  fault_response #(.OC_UNIT_TICKS_P(2), .RETRY_MIN_TICKS_P(2)) fault_response_inst (
    .clock, .rst, .ce, .cmd_write, .cmd_read, .cmd_code, .cmd_data, .clear_faults,
    .reset_cmd, .run_pin, .op_on, .ov_detect, .uv_detect, .uv_warn_detect, .uv_reached,
    .oc_detect, .ton_elapsed, .ton_delay_done, .ton_rise_active, .toff_fall_active,
    .alert_mask, .retry_ticks, .out_enable, .pull_down, .current_limit, .dcm_mode,
    .uv_warn, .alert_o, .alert_oe_n, .status_byte, .status_word_hi, .status_vout,
    .status_iout, .rd_data, .rd_valid
  );
  host_model host_model_inst (
    .clock, .rd_valid, .rd_data, .cmd_write, .cmd_read, .cmd_code, .cmd_data,
    .clear_faults, .run_pin, .op_on
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // bounded wait for the output enable to reach a level
  task automatic wait_en(input logic v, input int lim);
    int n = 0;
    while (out_enable !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk(8'(out_enable), 8'(v));
    if (out_enable !== v) end_of_test();
  endtask : wait_en
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_model_inst.wr(c, d);
  endtask : wr
  task automatic rchk(input logic [7:0] c, input logic [7:0] e);
    host_model_inst.rd(c, rv);
    chk(rv, e);
    if (rv === 8'hEE) end_of_test();
  endtask : rchk
  task automatic onoff(input logic v);
    host_model_inst.run(v, v);
  endtask : onoff

  task automatic s_regs();
    logic [7:0] ok [7] = '{8'h00, 8'h80, 8'h40, 8'h47, 8'h78, 8'h7F, 8'hB8};
    rchk(CMD_UV_ACTION, 8'hB8);
    rchk(CMD_OC_ACTION, 8'h00);
    rchk(CMD_TON_ACTION, 8'hB8);
    foreach (ok[i]) begin
      wr(CMD_OV_ACTION, ok[i]);
      rchk(CMD_OV_ACTION, ok[i]);
    end
    wr(CMD_OV_ACTION, 8'h81);
    wr(CMD_UV_ACTION, 8'hC5);
    wr(CMD_OC_ACTION, 8'h40);
    rchk(CMD_OV_ACTION, 8'hB8);
    rchk(CMD_UV_ACTION, 8'hB8);
    rchk(CMD_OC_ACTION, 8'h00);
    chk(status_byte, 8'h02);
    chk(8'(alert_oe_n), 8'h00);
    chk(8'(alert_o), 8'h00);
    host_model_inst.clr();
    cyc(3);
    chk(status_byte, 8'h00);
    chk(8'(alert_oe_n), 8'h01);
  endtask : s_regs
  task automatic s_ov_retry();
    onoff(1'b1);
    cyc(3);
    ov_detect = 1'b1;
    wait_en(1'b0, 3);
    ov_detect = 1'b0;
    chk(status_byte, 8'h20);
    chk(status_word_hi, 8'h80);
    chk(status_vout, 8'h80);
    chk(8'(alert_oe_n), 8'h00);
    cyc(3900);
    chk(8'(out_enable), 8'h00);
    wait_en(1'b1, 4300);
    alert_mask = 5'h01;
    cyc(3);
    chk(8'(alert_oe_n), 8'h01);
    alert_mask = 5'h00;
  endtask : s_ov_retry
  task automatic s_ov_glitch();
    wr(CMD_OV_ACTION, 8'h43);
    ov_detect = 1'b1;
    cyc(3900);
    chk(8'(out_enable), 8'h01);
    wait_en(1'b0, 4300);
    ov_detect = 1'b0;
    cyc(6500);
    chk(8'(out_enable), 8'h00);
    reset_cmd = 1'b1;
    cyc(1);
    reset_cmd = 1'b0;
    wait_en(1'b1, 10);
    wr(CMD_OV_ACTION, 8'h40);
    ov_detect = 1'b1;
    wait_en(1'b0, 10);
    ov_detect = 1'b0;
    onoff(1'b0);
    cyc(3);
    onoff(1'b1);
    wait_en(1'b1, 10);
    wr(CMD_OV_ACTION, 8'h78);
    ov_detect = 1'b1;
    wait_en(1'b0, 10);
    ov_detect = 1'b0;
    wait_en(1'b1, 8300);
    wr(CMD_OV_ACTION, OV_PULL_DOWN_ONLY);
    ov_detect = 1'b1;
    cyc(3);
    chk(8'(pull_down), 8'h01);
    chk(8'(out_enable), 8'h01);
    ov_detect = 1'b0;
    cyc(3);
    chk(8'(pull_down), 8'h00);
  endtask : s_ov_glitch
  task automatic s_oc();
    host_model_inst.clr();
    oc_detect = 1'b1;
    cyc(3);
    chk(8'(current_limit), 8'h01);
    chk(8'(out_enable), 8'h01);
    chk(status_byte, 8'h11);
    chk(status_word_hi, 8'h40);
    chk(status_iout, 8'h80);
    oc_detect = 1'b0;
    wr(CMD_OC_ACTION, 8'hC0);
    oc_detect = 1'b1;
    wait_en(1'b0, 10);
    oc_detect = 1'b0;
    cyc(6500);
    chk(8'(out_enable), 8'h00);
    host_model_inst.run(1'b0, 1'b1);
    cyc(3);
    onoff(1'b1);
    wait_en(1'b1, 10);
  endtask : s_oc
  task automatic s_uv_ton();
    wr(CMD_UV_ACTION, 8'h00);
    onoff(1'b0);
    {ton_delay_done, ton_rise_active} = 2'b11;
    cyc(3);
    onoff(1'b1);
    {uv_detect, uv_warn_detect} = 2'b11;
    cyc(3);
    chk(status_vout, 8'h00);
    chk(8'(uv_warn), 8'h00);
    chk(8'(dcm_mode), 8'h01);
    ton_rise_active = 1'b0;
    cyc(3);
    chk(status_vout, 8'h00);
    ton_elapsed = 1'b1;
    cyc(3);
    chk(status_vout, 8'h04);
    chk(8'(dcm_mode), 8'h00);
    ton_elapsed = 1'b0;
    wait_en(1'b1, 8300);
    host_model_inst.clr();
    uv_reached = 1'b1;
    cyc(3);
    chk(status_vout, 8'h10);
    chk(status_byte, 8'h01);
    chk(8'(uv_warn), 8'h01);
    chk(8'(out_enable), 8'h01);
    {uv_detect, uv_warn_detect, uv_reached} = 3'b000;
    wr(CMD_TON_ACTION, TON_DISABLED);
    onoff(1'b0);
    cyc(3);
    onoff(1'b1);
    ton_elapsed = 1'b1;
    cyc(3);
    chk(status_vout, 8'h00);
  endtask : s_uv_ton

  initial begin
    {rst, ce, reset_cmd} = 3'b110;
    {ov_detect, uv_detect, uv_warn_detect, uv_reached, oc_detect} = 5'h00;
    {ton_elapsed, ton_delay_done, ton_rise_active, toff_fall_active} = 4'h0;
    alert_mask  = 5'h00;
    retry_ticks = 24'h00_0003;
    fail_count  = 0;
    tests_run   = 0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    s_regs();
    s_ov_retry();
    s_ov_glitch();
    s_oc();
    s_uv_ton();
    end_of_test();
  end
endmodule : test_fault_response
`default_nettype wire
